/* core/was_pkg.sv */
// package: register layout, codes and timing for the auto-shutdown control
package was_pkg;
    localparam int unsigned ADDR_W         = 4;
    localparam int unsigned DATA_W         = 8;
    localparam logic [3:0]  REG_CTRL       = 4'h0;
    localparam logic [3:0]  REG_EVENT      = 4'h1;
    localparam logic [3:0]  REG_DEADBAND   = 4'h2;
    localparam int unsigned BIT_SHUTDOWN   = 7;
    localparam int unsigned BIT_RESTART    = 6;
    localparam int unsigned BD_LSB         = 4;
    localparam int unsigned AC_LSB         = 2;
    localparam int unsigned BIT_ENABLE     = 0;
    localparam int unsigned BIT_POL_AC     = 1;
    localparam int unsigned BIT_POL_BD     = 2;
    localparam logic [7:0]  CTRL_RESET     = 8'h14;
    localparam logic [7:0]  CTRL_WMASK     = 8'hfc;
    localparam logic [7:0]  DB_RESET       = 8'h04;
    localparam logic [7:0]  ZERO8          = 8'h00;
    localparam logic [1:0]  LVL_HIGH       = 2'b11;
    localparam logic [1:0]  LVL_LOW        = 2'b10;
    localparam logic [1:0]  LVL_TRI        = 2'b01;
    localparam logic [1:0]  LVL_INACTIVE   = 2'b00;
    typedef enum logic [2:0] {
        WAS_RUN  = 3'b001,
        WAS_SHUT = 3'b010,
        WAS_WAIT = 3'b100
    } was_state_e;
endpackage : was_pkg

/* core/was_sync.sv */
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module was_sync (
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    input  wire logic i_ce,
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= 1'b0;
            o_sync <= 1'b0;
        end else if (i_ce) begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // was_sync
`default_nettype wire

/* core/was_pair_out.sv */
// output stage of one pair: picks normal drive or a shutdown level
`timescale 1ns/10ps
`default_nettype none
module was_pair_out (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_ce,
    input  wire logic       i_shut,
    input  wire logic       i_db_done,
    input  wire logic [1:0] i_level,
    input  wire logic       i_pol,
    input  wire logic [1:0] i_norm,
    output logic      [1:0] o_pin,
    output logic      [1:0] o_oe
);
    import was_pkg::*;

    // registered pin and enable per output of the pair
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_pin <= 2'b00;
            o_oe  <= 2'b00;
        end else if (i_ce) begin
            if (!i_shut) begin
                o_pin <= i_norm;
                o_oe  <= 2'b11;
            end else begin
                unique case (i_level)
                    LVL_HIGH: begin
                        o_pin <= 2'b11;
                        o_oe  <= 2'b11;
                    end
                    LVL_LOW: begin
                        o_pin <= 2'b00;
                        o_oe  <= 2'b11;
                    end
                    LVL_TRI: begin
                        o_pin <= 2'b00;
                        o_oe  <= 2'b00;
                    end
                    LVL_INACTIVE: begin
                        // inactive level waits out the dead band
                        if (i_db_done) begin
                            o_pin <= {2{i_pol}};
                        end
                        o_oe <= 2'b11;
                    end
                endcase
            end
        end
    end
endmodule // was_pair_out
`default_nettype wire

/* core/was_ctrl.sv */
// auto-shutdown control of a four-output complementary waveform generator
`timescale 1ns/10ps
`default_nettype none
// How it works
// - status bit 7 follows shutdown state
// - after clear, wait data rising edge
// - pair B/D follows bits 5-4 code
// - pair A/C follows bits 3-2 code
// - code 00 gives inactive level after dead band
module was_ctrl #(
    parameter int unsigned DB_W = 8
) (
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_rstn,
    input  wire logic                       i_ce,
    input  wire logic [was_pkg::ADDR_W-1:0] i_addr,
    input  wire logic [was_pkg::DATA_W-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [was_pkg::DATA_W-1:0] o_rdata,
    input  wire logic                       i_shut_event,
    input  wire logic                       i_data_in,
    input  wire logic [3:0]                 i_norm,
    output logic      [3:0]                 o_pin,
    output logic      [3:0]                 o_oe
);
    import was_pkg::*;

    // refuse a dead band width that the read path cannot carry
    if (DB_W < 1 || DB_W > DATA_W) begin : g_bad_db_w
        $error("was_ctrl: DB_W out of range");
    end

    was_state_e         state_q;
    logic [7:0]         ctrl_q;
    logic [7:0]         evcfg_q;
    logic [DB_W-1:0]    db_len_q;
    logic [DB_W-1:0]    db_cnt_q;
    logic               db_done_q;
    logic               event_s;
    logic               data_s;
    logic               data_prev_q;
    logic               data_rise;
    logic               enabled;
    logic               wr_ctrl;
    logic               sw_set;
    logic               sw_clr;
    logic               shut_act;
    logic [1:0]         ac_norm;
    logic [1:0]         bd_norm;
    logic [1:0]         ac_pin;
    logic [1:0]         ac_oe;
    logic [1:0]         bd_pin;
    logic [1:0]         bd_oe;
    logic [DATA_W-1:0]  db_rd;

    // pin inputs pass two flops before use
    was_sync u_sync_event (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_async   (i_shut_event),
        .o_sync    (event_s)
    );

    was_sync u_sync_data (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_async   (i_data_in),
        .o_sync    (data_s)
    );

    // decode of software control writes
    assign enabled = evcfg_q[BIT_ENABLE];
    assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
    assign sw_set  = wr_ctrl && i_wdata[BIT_SHUTDOWN] && !enabled;
    assign sw_clr  = wr_ctrl && !i_wdata[BIT_SHUTDOWN];
    assign data_rise = data_s && !data_prev_q;
    assign shut_act  = (state_q != WAS_RUN);

    // edge detector on the synchronised data input
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            data_prev_q <= 1'b0;
        end else if (i_ce) begin
            data_prev_q <= data_s;
        end
    end

    // shutdown sequencing: run, shut, wait for data edge
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= WAS_RUN;
        end else if (i_ce) begin
            unique case (state_q)
                WAS_RUN: begin
                    if (event_s || sw_set) begin
                        state_q <= WAS_SHUT;
                    end
                end
                WAS_SHUT: begin
                    // event level holds shutdown; the event wins over a clear
                    if (!event_s && (sw_clr || ctrl_q[BIT_RESTART])) begin
                        state_q <= WAS_WAIT;
                    end
                end
                WAS_WAIT: begin
                    // a software set while waiting re-enters shutdown
                    if (event_s || sw_set) begin
                        state_q <= WAS_SHUT;
                    end else if (data_rise) begin
                        state_q <= WAS_RUN;
                    end
                end
                default: begin
                    state_q <= WAS_SHUT;
                end
            endcase
        end
    end

    // control register: status bit is hardware owned
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_q <= CTRL_RESET;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                ctrl_q[6:0] <= i_wdata[6:0] & CTRL_WMASK[6:0];
            end
            ctrl_q[BIT_SHUTDOWN] <= (state_q == WAS_SHUT)
                || ((state_q == WAS_RUN) && (event_s || sw_set))
                || ((state_q == WAS_WAIT) && (event_s || sw_set));
        end
    end

    // enable and polarity register, dead band length register
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            evcfg_q  <= ZERO8;
            db_len_q <= DB_RESET[DB_W-1:0];
        end else if (i_ce) begin
            if (i_wr && (i_addr == REG_EVENT)) begin
                evcfg_q <= {5'h00, i_wdata[2:0]};
            end
            if (i_wr && (i_addr == REG_DEADBAND)) begin
                db_len_q <= i_wdata[DB_W-1:0];
            end
        end
    end

    // dead band timer started on entry to shutdown, by the event or by a software set
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            db_cnt_q  <= '0;
            db_done_q <= 1'b0;
        end else if (i_ce) begin
            if (!shut_act) begin
                db_cnt_q  <= '0;
                db_done_q <= 1'b0;
            end else if (!db_done_q) begin
                if (db_cnt_q >= db_len_q) begin
                    db_done_q <= 1'b1;
                end else begin
                    db_cnt_q <= db_cnt_q + 1'b1;
                end
            end
        end
    end

    // normal drive: A-D from generator only while enabled
    assign ac_norm = enabled ? {i_norm[2], i_norm[0]} : 2'b00;
    assign bd_norm = enabled ? {i_norm[3], i_norm[1]} : 2'b00;

    // first pair (A, C)
    was_pair_out u_pair_ac (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_shut    (shut_act),
        .i_db_done (db_done_q),
        .i_level   (ctrl_q[AC_LSB +: 2]),
        .i_pol     (evcfg_q[BIT_POL_AC]),
        .i_norm    (ac_norm),
        .o_pin     (ac_pin),
        .o_oe      (ac_oe)
    );

    // second pair (B, D)
    was_pair_out u_pair_bd (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_ce      (i_ce),
        .i_shut    (shut_act),
        .i_db_done (db_done_q),
        .i_level   (ctrl_q[BD_LSB +: 2]),
        .i_pol     (evcfg_q[BIT_POL_BD]),
        .i_norm    (bd_norm),
        .o_pin     (bd_pin),
        .o_oe      (bd_oe)
    );

    // pins ordered A, B, C, D; pair stages are already registered
    assign o_pin = {bd_pin[1], ac_pin[1], bd_pin[0], ac_pin[0]};
    assign o_oe  = {bd_oe[1], ac_oe[1], bd_oe[0], ac_oe[0]};

    // dead band length zero-extended to the bus width for reads
    always_comb begin
        db_rd = '0;
        db_rd[DB_W-1:0] = db_len_q;
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= ZERO8;
        end else if (i_ce) begin
            if (i_rd) begin
                unique case (i_addr)
                    REG_CTRL:     o_rdata <= ctrl_q;
                    REG_EVENT:    o_rdata <= evcfg_q;
                    REG_DEADBAND: o_rdata <= db_rd;
                    default:      o_rdata <= ZERO8;
                endcase
            end else begin
                o_rdata <= ZERO8;
            end
        end
    end
endmodule // was_ctrl
`default_nettype wire

/* tb/was_switch_model.sv */
// far-side model: power switches whose gates carry pull-down resistors
`timescale 1ns/10ps
`default_nettype none
module was_switch_model (
    input  wire logic [3:0] i_pin,
    input  wire logic [3:0] i_oe,
    output logic      [3:0] o_line
);
    // an undriven gate line is pulled low by its resistor
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            o_line[b] = i_oe[b] ? i_pin[b] : 1'b0;
        end
    end
endmodule // was_switch_model
`default_nettype wire

/* tb/was_ctrl_properties.sv */
// concurrent checks on the ports of the auto-shutdown control
`timescale 1ns/10ps
`default_nettype none
module was_ctrl_checker
    import was_pkg::*;
#(
    parameter int unsigned DB_W = 8
) (
    input wire logic                       i_ref_clk,
    input wire logic                       i_rstn,
    input wire logic                       i_ce,
    input wire logic [was_pkg::ADDR_W-1:0] i_addr,
    input wire logic [was_pkg::DATA_W-1:0] i_wdata,
    input wire logic                       i_wr,
    input wire logic                       i_rd,
    input wire logic [was_pkg::DATA_W-1:0] o_rdata,
    input wire logic                       i_shut_event,
    input wire logic                       i_data_in,
    input wire logic [3:0]                 i_norm,
    input wire logic [3:0]                 o_pin,
    input wire logic [3:0]                 o_oe
);
    logic [3:0] lvl_q;
    logic [2:0] cfg_q;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rstn);
    // shadow copies of the level fields and the event settings
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            lvl_q <= CTRL_RESET[5:2];
            cfg_q <= 3'h0;
        end else if (i_ce && i_wr && i_addr == REG_CTRL) begin
            lvl_q <= i_wdata[5:2];
        end else if (i_ce && i_wr && i_addr == REG_EVENT) begin
            cfg_q <= i_wdata[2:0];
        end
    end
    // true when a pair shows what its level code asks for
    function automatic logic lv_ok(input logic [1:0] c,
                                   input logic [1:0] p,
                                   input logic [1:0] e);
        case (c)
            LVL_HIGH: return p == 2'b11 && e == 2'b11;
            LVL_LOW:  return p == 2'b00 && e == 2'b11;
            LVL_TRI:  return e == 2'b00;
            default:  return 1'b1;
        endcase
    endfunction
    chk_status_set: assert property (
        i_shut_event [*5] ##0 (i_ce && i_rd && i_addr == REG_CTRL)
        |=> o_rdata[BIT_SHUTDOWN])
        else $error("status bit low during a held shutdown event");
    chk_sw_shut: assert property (
        (i_ce && i_wr && i_addr == REG_CTRL && i_wdata[7] && !cfg_q[0]
         && i_wdata[5:4] == LVL_HIGH)
        |-> ##[1:4] (o_pin[3] && o_pin[1] && o_oe[3] && o_oe[1]))
        else $error("software shutdown did not drive the pins");
    chk_hold_level: assert property (
        i_shut_event [*8] ##1 (!i_data_in) [*8]
        |-> $stable(o_oe) && $stable(o_pin & o_oe))
        else $error("pins left shutdown before a data rising edge");
    chk_bd_level: assert property (
        i_shut_event [*7]
        |-> lv_ok(lvl_q[3:2], {o_pin[3], o_pin[1]}, {o_oe[3], o_oe[1]}))
        else $error("second pair level does not match its code");
    chk_ac_level: assert property (
        i_shut_event [*7]
        |-> lv_ok(lvl_q[1:0], {o_pin[2], o_pin[0]}, {o_oe[2], o_oe[0]}))
        else $error("first pair level does not match its code");
    chk_inactive_pol: assert property (
        i_shut_event [*8] ##1 i_shut_event [*8] ##0 lvl_q == 4'h0
        |-> o_oe == 4'hf && o_pin == {cfg_q[2], cfg_q[1], cfg_q[2], cfg_q[1]})
        else $error("inactive level or polarity wrong after dead band");
endmodule // was_ctrl_checker
bind was_ctrl was_ctrl_checker #(.DB_W(DB_W)) i_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_shut_event(i_shut_event), .i_data_in(i_data_in), .i_norm(i_norm),
    .o_pin(o_pin), .o_oe(o_oe));
`default_nettype wire

/* tb/waveform_auto_shutdown_ctrl_bench.sv */
// self-checking bench for the auto-shutdown control
`timescale 1ns/10ps
`default_nettype none
module waveform_auto_shutdown_ctrl_bench;
    import was_pkg::*;
    logic       i_ref_clk = 1'b0;
    logic       i_rstn    = 1'b0;
    logic [3:0] i_addr    = 4'h0;
    logic [7:0] i_wdata   = 8'h00;
    logic       i_wr      = 1'b0;
    logic       i_rd      = 1'b0;
    logic       i_shut_ev = 1'b0;
    logic       i_data_in = 1'b0;
    logic [3:0] i_norm    = 4'h0;
    logic [3:0] nrm       = 4'h0;
    logic       pin_chk   = 1'b0;
    logic       rd_prev   = 1'b0;
    logic [7:0] o_rdata;
    logic [3:0] o_pin;
    logic [3:0] o_oe;
    logic [3:0] line;
    logic [7:0] rd_q[$];
    logic [7:0] pin_q[$];
    int         error_cnt = 0;
    int         tests_run = 0;
    // level codes per row: control value, event settings, {oe, line}
    logic [7:0] ct_t[6] = '{8'h38, 8'h14, 8'h24, 8'h1c, 8'h08, 8'h00};
    logic [7:0] ev_t[6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h05, 8'h07};
    logic [7:0] ex_t[6] = '{8'hfa, 8'h00, 8'ha0, 8'h55, 8'hfa, 8'hff};
    // 10 MHz reference clock
    always #50 i_ref_clk = ~i_ref_clk;
    was_ctrl #(.DB_W(8)) i_dut (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(1'b1),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_shut_event(i_shut_ev),
        .i_data_in(i_data_in), .i_norm(i_norm), .o_pin(o_pin),
        .o_oe(o_oe));
    was_switch_model i_sw (.i_pin(o_pin), .i_oe(o_oe), .o_line(line));
    task automatic complete_run;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_ref_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        rd_q.push_back(e);
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
    endtask
    // optionally wait (bounded) for the pins, then note the expectation
    task automatic pins(input logic [7:0] e, input bit w);
        int n;
        n = 0;
        while (w && {o_oe, line} !== e && n < 40) begin
            @(negedge i_ref_clk);
            n++;
        end
        // bound used up: count it and go to the closing report
        if (w && {o_oe, line} !== e) begin
            error_cnt++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, {o_oe, line});
            complete_run();
        end
        @(posedge i_ref_clk);
        pin_chk <= 1'b1;
        pin_q.push_back(e);
        @(posedge i_ref_clk);
        pin_chk <= 1'b0;
    endtask
    // clear the status, see the pins hold, then release by a data edge
    task automatic restart(input logic [7:0] c, input logic [7:0] held,
                           input logic [7:0] run);
        repeat (4) @(posedge i_ref_clk);
        wr(REG_CTRL, c);
        rd(REG_CTRL, c);
        pins(held, 1'b0);
        i_data_in <= 1'b1;
        pins(run, 1'b1);
        i_data_in <= 1'b0;
    endtask
    // result watcher: read data and pin notes are compared in order
    always @(negedge i_ref_clk) begin
        if (rd_prev) cmp(rd_q.pop_front(), o_rdata);
        if (pin_chk) cmp(pin_q.pop_front(), {o_oe, line});
        rd_prev <= i_rd;
    end
    // hang guard
    initial begin
        #3000000;
        error_cnt++;
        complete_run();
    end
    // main sequence
    initial begin
        void'($urandom(92));
        nrm = (4'($urandom) | 4'h1) & 4'h7; // differs from every level row
        repeat (16) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        i_norm <= nrm;
        rd(REG_CTRL, CTRL_RESET);
        rd(REG_EVENT, ZERO8);
        rd(REG_DEADBAND, DB_RESET);
        rd(4'hf, ZERO8);
        wr(REG_CTRL, 8'hb8);
        pins(8'hfa, 1'b1);
        rd(REG_CTRL, 8'hb8);
        restart(8'h38, 8'hfa, 8'hf0);
        for (int k = 0; k < 6; k++) begin
            wr(REG_EVENT, ev_t[k]);
            wr(REG_CTRL, ct_t[k]);
            i_shut_ev <= 1'b1;
            pins(ex_t[k], 1'b1);
            rd(REG_CTRL, ct_t[k] | 8'h80);
            wr(REG_CTRL, ct_t[k]);
            rd(REG_CTRL, ct_t[k] | 8'h80);
            i_shut_ev <= 1'b0;
            restart(ct_t[k], ex_t[k], {4'hf, nrm});
        end
        // auto restart: the status clears itself once the event is gone
        wr(REG_CTRL, 8'h78);
        i_shut_ev <= 1'b1;
        pins(8'hfa, 1'b1);
        i_shut_ev <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        rd(REG_CTRL, 8'h78);
        pins(8'hfa, 1'b0);
        i_data_in <= 1'b1;
        pins({4'hf, nrm}, 1'b1);
        i_data_in <= 1'b0;
        // software set is refused while the generator is enabled
        wr(REG_CTRL, 8'hb8);
        rd(REG_CTRL, 8'h38);
        pins({4'hf, nrm}, 1'b0);
        // longer dead band: inactive level must not appear early
        wr(REG_DEADBAND, 8'h09);
        rd(REG_DEADBAND, 8'h09);
        wr(REG_CTRL, 8'h00);
        i_shut_ev <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        pins({4'hf, nrm}, 1'b0);
        pins(8'hff, 1'b1);
        i_shut_ev <= 1'b0;
        restart(8'h00, 8'hff, {4'hf, nrm});
        repeat (2) @(posedge i_ref_clk);
        complete_run();
    end
endmodule // waveform_auto_shutdown_ctrl_bench
`default_nettype wire
